// *** src/aabl_lock_ctrl.sv ***
`timescale 1ns/100ps
module aabl_lock_ctrl
    import aabl_pkg::*;
#(
    parameter aabl_gen_t GEN = GEN_NEWER,
    parameter int LINE_BYTES = LINE_BYTES_DEF
)
(
    input wire logic clk,
    input wire logic rst,
    input wire aabl_req_t req,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [DATA_W-1:0] modData,
    input wire logic modValid,
    input wire logic pendLoads,
    input wire logic pendStores,
    input wire logic onlyWeakLoads,
    output aabl_bus_t busOut,
    input wire logic busAck,
    input wire logic [DATA_W-1:0] busRdata,
    output logic busLock,
    output logic cacheLock,
    output logic orderHold,
    output logic done,
    output logic fault,
    output logic wasSet,
    output logic [DATA_W-1:0] rdData
);
    localparam int WIDE_W = 2 * DATA_W;

    aabl_state_t state;
    aabl_state_t next_state;
    aabl_req_t cur;
    aabl_req_t sel;
    logic beat;
    logic next_beat;
    logic [DATA_W-1:0] lowBeat;
    logic [DATA_W-1:0] newVal;
    logic [DATA_W-1:0] next_newVal;
    logic [WIDE_W-1:0] rdNow;
    logic [WIDE_W-1:0] wideW;
    logic [DATA_W-1:0] operandNow;
    logic [BE_W-1:0] byteMask;
    logic [5:0] shAmt;
    logic atomic;
    logic crossBus;
    logic crossLine;
    logic lastBeat;
    logic accept;
    logic illegal;
    logic locked;
    logic drained;
    logic usePin;
    logic flagsSet;
    logic skipWrite;
    logic readEnds;
    logic finish;

    // ========================================
    // request decode

    // the prefix is legal only on read-modify-write of memory
    function automatic logic prefixOk(input aabl_req_t r);
        prefixOk = r.memDest && r.cls != CLS_OTHER;
    endfunction

    // automatic locking covers system updates, swap and int ack
    function automatic logic needLock(input aabl_req_t r);
        needLock = 1'b0;
        // a register-only swap never reaches the bus, so no lock
        if (r.op == OP_INSN)
            needLock = r.lockPrefix
                || (r.cls == CLS_SWAP && r.memDest);
        else if (r.op == OP_TASK_BUSY)
            needLock = 1'b1;
        else if (r.op == OP_DESC_ACC)
            needLock = 1'b1;
        else if (r.op == OP_PAGE_FLAG)
            needLock = 1'b1;
        else if (r.op == OP_INT_ACK)
            needLock = 1'b1;
    endfunction

    // taken only while idle; an illegal request only faults
    assign accept = (state == ST_IDLE) && reqValid;
    assign illegal = req.op == OP_INSN && req.lockPrefix && !prefixOk(req);
    // the live request steers the check until it is captured
    assign sel = (state == ST_IDLE) ? req : cur;

    // ========================================
    // atomicity and byte lanes of the selected access
    aabl_atomic_check #(
        .GEN(GEN),
        .LINE_BYTES(LINE_BYTES)
    ) u_check (
        .size(sel.size),
        .offs(sel.addr[PG_W-1:0]),
        .cacheable(sel.cacheable),
        .cached(sel.cached),
        .atomic(atomic),
        .crossBus(crossBus),
        .crossLine(crossLine),
        .byteMask(byteMask)
    );

    // interrupt acknowledge is one vector cycle, never split
    assign lastBeat = crossBus && sel.op != OP_INT_ACK;
    assign shAmt = {sel.addr[BO_W-1:0], 3'h0};

    // ========================================
    // ordering and lock mode

    // weak loads may stay in flight only on the newest generation
    assign drained = !pendStores
        && (!pendLoads || (GEN == GEN_NEWER && onlyWeakLoads));

    // a cached line on the newest generation is locked internally
    // a line-crossing access falls back to the pin lock
    assign usePin = !(GEN == GEN_NEWER && cur.cacheable && cur.cached
        && !crossLine);

    // ========================================
    // read data assembly across one or two beats
    assign rdNow = beat ? {busRdata, lowBeat} : {{DATA_W{1'b0}}, busRdata};
    assign operandNow = DATA_W'(rdNow >> shAmt);
    assign flagsSet = (operandNow & cur.operand) == cur.operand;

    // oldest generation rewrites the accessed flag even if set
    assign skipWrite = cur.op == OP_DESC_ACC && flagsSet
        && GEN != GEN_OLDEST;
    assign readEnds = (state == ST_RD) && busAck && beat == lastBeat;
    // write value moved onto the operand's byte lanes
    assign wideW = {{DATA_W{1'b0}}, next_newVal} << shAmt;

    // ========================================
    // sequencer
    always_comb
    begin
        next_state = state;
        next_beat = beat;
        next_newVal = newVal;
        finish = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                if (reqValid && !illegal)
                begin
                    next_beat = 1'b0;
                    next_newVal = req.operand;
                    if (req.op == OP_INT_ACK)
                        next_state = ST_RD;
                    else if (needLock(req))
                        next_state = ST_DRAIN;
                    else if (req.op == OP_PLAIN_WR)
                        next_state = ST_WR;
                    else
                        next_state = ST_RD;
                end
            end
            ST_DRAIN:
            begin
                if (drained)
                    next_state = ST_RD;
            end
            ST_RD:
            begin
                // low bus word first, then the next one for a split
                if (busAck && beat != lastBeat)
                    next_beat = 1'b1;
                else if (busAck)
                begin
                    next_beat = 1'b0;
                    if (cur.op == OP_PLAIN_RD || cur.op == OP_INT_ACK)
                        finish = 1'b1;
                    else if (skipWrite)
                        finish = 1'b1;
                    else if (cur.op == OP_INSN)
                        next_state = ST_MOD;
                    else
                    begin
                        // flag ops set their mask bits
                        next_newVal = operandNow | cur.operand;
                        next_state = ST_WR;
                    end
                end
            end
            ST_MOD:
            begin
                // lock stays up while the core works out the new value
                if (modValid)
                begin
                    next_newVal = modData;
                    next_state = ST_WR;
                end
            end
            ST_WR:
            begin
                // the lock holds until the last write beat is acked
                if (busAck && beat != lastBeat)
                    next_beat = 1'b1;
                else if (busAck)
                    finish = 1'b1;
            end
        endcase
        if (finish)
            next_state = ST_IDLE;
    end

    // ========================================
    // state registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            beat <= 1'b0;
            newVal <= '0;
        end
        else
        begin
            state <= next_state;
            beat <= next_beat;
            newVal <= next_newVal;
        end
    end

    // request held for the whole sequence
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cur <= '0;
        else if (accept)
            cur <= req;
    end

    // first beat kept so a split read assembles whole
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lowBeat <= '0;
        else if (state == ST_RD && busAck && !beat)
            lowBeat <= busRdata;
    end

    // ========================================
    // bus cycle outputs, computed from next state so they are flops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            busOut <= '0;
        else
        begin
            busOut.req <= next_state == ST_RD || next_state == ST_WR;
            busOut.write <= next_state == ST_WR;
            busOut.intAck <= sel.op == OP_INT_ACK
                && next_state == ST_RD;
            // non-atomic splits are flagged so memory can glue them
            busOut.split <= crossBus && !atomic
                && sel.op != OP_INT_ACK;
            // a second beat goes to the next bus word up
            busOut.addr <= {sel.addr[ADDR_W-1:BO_W]
                + (ADDR_W - BO_W)'(next_beat), BO_W'(0)};
            busOut.be <= next_beat ? byteMask[BE_W-1:BUS_BYTES]
                : byteMask[BUS_BYTES-1:0];
            busOut.wdata <= next_beat ? wideW[WIDE_W-1:DATA_W]
                : wideW[DATA_W-1:0];
        end
    end

    // ========================================
    // bus lock pin: raised once the pipe drains, or on the take for int ack; dropped on the final ack of the sequence
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            busLock <= 1'b0;
        else if (finish)
            busLock <= 1'b0;
        // int ack skips the drain: the vector must not wait on stores
        else if (accept && !illegal && req.op == OP_INT_ACK)
            busLock <= 1'b1;
        else if (state == ST_DRAIN && drained && usePin)
            busLock <= 1'b1;
    end

    // internal cache lock in place of the pin
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cacheLock <= 1'b0;
        else if (finish)
            cacheLock <= 1'b0;
        else if (state == ST_DRAIN && drained && !usePin)
            cacheLock <= 1'b1;
    end

    // core may pass only fetches and page walks while this is high
    assign locked = needLock(req) && !illegal;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            orderHold <= 1'b0;
        else if (finish)
            orderHold <= 1'b0;
        else if (accept && locked)
            orderHold <= 1'b1;
    end

    // ========================================
    // results to the core
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done <= 1'b0;
            fault <= 1'b0;
            reqReady <= 1'b0;
        end
        else
        begin
            done <= finish;
            fault <= accept && illegal;
            // ready follows next state, so it drops on the take edge
            reqReady <= next_state == ST_IDLE;
        end
    end

    // read value and prior flag state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdData <= '0;
            wasSet <= 1'b0;
        end
        else if (readEnds)
        begin
            rdData <= operandNow;
            wasSet <= flagsSet;
        end
    end

endmodule

// *** include/aabl_pkg.sv ***
// Function
// - bytes, aligned words, dwords are atomic
// - aligned quadwords are atomic
// - uncached word inside 32-bit window atomic
// - unaligned cached access within line atomic
// - bus, line, page splits not guaranteed
// - mark split accesses for external memory
// - assert bus lock in critical operations
// - older generations pin-lock every prefixed op
// - newer generation cache-locks cached lines
// - swap with memory always locks
// - task busy flag locked test-and-set
// - lock accessed flag set; skip rules
// - page entry flag updates use lock
// - lock held over interrupt acknowledge
// - illegal lock prefix raises opcode fault
// - lock covers destination operand bytes
// - lock held across all split cycles
// - locked ops atomic against other traffic
// - lock waits for outstanding loads, stores
package aabl_pkg;

    // ========================================
    // widths and geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int BUS_BYTES = 8;
    localparam int BO_W = 3;
    localparam int BE_W = 2 * BUS_BYTES;
    localparam int W32_W = 2;
    localparam int PG_W = 12;
    localparam int LINE_BYTES_DEF = 64;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_DWORD = 2'h2;
    localparam logic [1:0] SZ_QWORD = 2'h3;
    localparam logic [BE_W-1:0] BE_BYTE = 16'h0001;
    localparam logic [BE_W-1:0] BE_WORD = 16'h0003;
    localparam logic [BE_W-1:0] BE_DWORD = 16'h000F;
    localparam logic [BE_W-1:0] BE_QWORD = 16'h00FF;

    // ========================================
    // enumerations
    typedef enum logic [1:0]
    {
        GEN_OLDEST = 2'h0,
        GEN_OLDER = 2'h1,
        GEN_MID = 2'h2,
        GEN_NEWER = 2'h3
    } aabl_gen_t;

    typedef enum logic [2:0]
    {
        OP_PLAIN_RD = 3'h0,
        OP_PLAIN_WR = 3'h1,
        OP_INSN = 3'h2,
        OP_TASK_BUSY = 3'h3,
        OP_DESC_ACC = 3'h4,
        OP_PAGE_FLAG = 3'h5,
        OP_INT_ACK = 3'h6
    } aabl_op_t;

    typedef enum logic [2:0]
    {
        CLS_BIT_TEST = 3'h0,
        CLS_SWAP_ADD = 3'h1,
        CLS_CMP_SWAP = 3'h2,
        CLS_SWAP = 3'h3,
        CLS_UNARY = 3'h4,
        CLS_BINARY = 3'h5,
        CLS_OTHER = 3'h6
    } aabl_cls_t;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_DRAIN = 5'h02,
        ST_RD = 5'h04,
        ST_MOD = 5'h08,
        ST_WR = 5'h10
    } aabl_state_t;

    // ========================================
    // carriers
    typedef struct packed
    {
        aabl_op_t op;
        aabl_cls_t cls;
        logic lockPrefix;
        logic memDest;
        logic [1:0] size;
        logic [ADDR_W-1:0] addr;
        logic cacheable;
        logic cached;
        logic [DATA_W-1:0] operand;
    } aabl_req_t;

    typedef struct packed
    {
        logic req;
        logic write;
        logic intAck;
        logic split;
        logic [ADDR_W-1:0] addr;
        logic [BUS_BYTES-1:0] be;
        logic [DATA_W-1:0] wdata;
    } aabl_bus_t;

endpackage

// *** src/aabl_atomic_check.sv ***
`timescale 1ns/100ps
module aabl_atomic_check
    import aabl_pkg::*;
#(
    parameter aabl_gen_t GEN = GEN_NEWER,
    parameter int LINE_BYTES = LINE_BYTES_DEF
)
(
    input wire logic [1:0] size,
    input wire logic [PG_W-1:0] offs,
    input wire logic cacheable,
    input wire logic cached,
    output logic atomic,
    output logic crossBus,
    output logic crossLine,
    output logic [BE_W-1:0] byteMask
);
    localparam int SUM_W = PG_W + 1;
    localparam int LN_W = $clog2(LINE_BYTES);

    logic [SUM_W-1:0] nBytes;
    logic [SUM_W-1:0] first;
    logic [SUM_W-1:0] last;
    logic aligned;
    logic crossW32;

    // ========================================
    // extent of the access inside its page
    assign nBytes = SUM_W'(1) << size;
    assign first = {1'b0, offs};
    assign last = first + nBytes - SUM_W'(1);
    assign aligned = (first & (nBytes - SUM_W'(1))) == '0;
    assign crossBus = last[SUM_W-1:BO_W] != first[SUM_W-1:BO_W];
    assign crossLine = last[SUM_W-1:LN_W] != first[SUM_W-1:LN_W];
    assign crossW32 = last[SUM_W-1:W32_W] != first[SUM_W-1:W32_W];

    // ========================================
    // guarantees grow with generation; line splits stay unguaranteed
    always_comb
    begin
        atomic = (size == SZ_BYTE);
        if (aligned && size != SZ_QWORD)
            atomic = 1'b1;
        if (GEN >= GEN_MID && aligned)
            atomic = 1'b1;
        if (GEN >= GEN_MID && !cacheable && size == SZ_WORD && !crossW32)
            atomic = 1'b1;
        if (GEN == GEN_NEWER && cacheable && cached && !crossLine)
            atomic = 1'b1;
    end

    // ========================================
    // enables over two bus beats, exactly the operand bytes
    always_comb
    begin
        unique case (size)
            SZ_BYTE: byteMask = BE_BYTE;
            SZ_WORD: byteMask = BE_WORD;
            SZ_DWORD: byteMask = BE_DWORD;
            SZ_QWORD: byteMask = BE_QWORD;
        endcase
        byteMask = byteMask << offs[BO_W-1:0];
    end

endmodule

// *** bench/aabl_lock_ctrl_props.sv ***
`timescale 1ns/100ps
module aabl_lock_ctrl_props
    import aabl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reqReady,
    input wire aabl_bus_t busOut,
    input wire logic busAck,
    input wire logic busLock,
    input wire logic cacheLock,
    input wire logic orderHold,
    input wire logic done,
    input wire logic fault
);
    // ========================================
    // timing and lock relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_fault_pulse: assert property (fault |=> !fault)
        else $error("fault longer than one cycle");
    chk_fault_nobus: assert property (
        fault |-> !busOut.req && !busLock)
        else $error("bus cycle beside fault");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    chk_done_ready: assert property (done |-> reqReady)
        else $error("ready not raised with done");
    chk_idle_quiet: assert property (reqReady |-> !busOut.req && !busLock)
        else $error("bus active while idle");
    chk_cache_pin: assert property (cacheLock |-> !busLock)
        else $error("pin lock with cache lock");
    chk_lock_order: assert property (
        busLock && !busOut.intAck |-> orderHold)
        else $error("pin lock without traffic hold");
    chk_beat_stands: assert property (
        busOut.req && !busAck |=> $stable(busOut))
        else $error("bus beat changed before ack");
    chk_lock_release: assert property ($fell(busLock) |->
        done && $past(busAck && busOut.req))
        else $error("lock dropped off an ack edge");
    chk_split_hold: assert property (
        busLock && busAck && busOut.req && busOut.split && !busOut.write
        |=> busLock)
        else $error("lock lost between split beats");

    // main scenarios reached
    cov_int_ack: cover property (busLock && busOut.intAck);
    cov_cache: cover property (cacheLock);
    cov_split: cover property (busLock && busOut.split && busAck);
endmodule

bind aabl_lock_ctrl aabl_lock_ctrl_props aabl_lock_ctrl_props_i
(
    .clk(clk), .rst(rst), .reqReady(reqReady), .busOut(busOut),
    .busAck(busAck), .busLock(busLock), .cacheLock(cacheLock),
    .orderHold(orderHold), .done(done), .fault(fault)
);

// *** bench/aabl_bus_model.sv ***
`timescale 1ns/100ps
module aabl_bus_model
    import aabl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire aabl_bus_t busOut,
    input wire logic busLock,
    input wire logic [1:0] dly,
    input wire logic [DATA_W-1:0] memVal,
    output logic busAck,
    output logic [DATA_W-1:0] busRdata,
    output int rdBeats,
    output int wrBeats,
    output int lockBeats,
    output int intBeats,
    output logic [DATA_W-1:0] lastWdata,
    output logic [BUS_BYTES-1:0] lastBe,
    output logic [ADDR_W-1:0] lastAddr,
    output int splitBeats
);
    logic [1:0] waitCnt;

    // ========================================
    // responder: ack after dly wait cycles, one beat at a time
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busAck <= 1'h0;
            waitCnt <= 2'h0;
        end
        else
        begin
            busAck <= busOut.req && !busAck && waitCnt >= dly;
            waitCnt <= (busOut.req && !busAck && waitCnt < dly) ?
                waitCnt + 2'h1 : 2'h0;
        end
    end

    // released data lines show inverted junk, never the last value
    assign busRdata = busAck ? memVal : ~memVal;

    // ========================================
    // beat log; beats acked while the pin lock is up are counted apart
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst || clr)
        begin
            rdBeats <= 0;
            wrBeats <= 0;
            lockBeats <= 0;
            intBeats <= 0;
            lastWdata <= '0;
            lastBe <= '0;
            lastAddr <= '0;
            splitBeats <= 0;
        end
        else if (busOut.req && busAck)
        begin
            lastBe <= busOut.be;
            lastAddr <= busOut.addr;
            if (busOut.split)
                splitBeats <= splitBeats + 1;
            if (busOut.write)
            begin
                wrBeats <= wrBeats + 1;
                lastWdata <= busOut.wdata;
            end
            else
                rdBeats <= rdBeats + 1;
            if (busLock)
                lockBeats <= lockBeats + 1;
            if (busOut.intAck)
                intBeats <= intBeats + 1;
        end
    end
endmodule

// *** bench/atomic_access_bus_lock_tb_top.sv ***
`timescale 1ns/100ps
module atomic_access_bus_lock_tb_top
    import aabl_pkg::*;
;
    logic clk, rst, reqValid, reqReady, modValid, pendLoads, pendStores;
    logic onlyWeakLoads, busAck, busLock, cacheLock, orderHold, done;
    logic fault, wasSet, clr, sawCache;
    logic [DATA_W-1:0] modData, busRdata, rdData, memVal, lastWdata;
    logic [1:0] dly;
    aabl_req_t req;
    aabl_bus_t busOut;
    int rdBeats, wrBeats, lockBeats, intBeats, miscompares, checks_done;
    int splitBeats;
    logic [BUS_BYTES-1:0] lastBe;
    logic [ADDR_W-1:0] lastAddr;
    localparam logic [63:0] MOD_VAL = 64'h0123456789ABCDEF;

    aabl_lock_ctrl aabl_lock_ctrl_i
    (
        .clk(clk), .rst(rst), .req(req), .reqValid(reqValid),
        .reqReady(reqReady), .modData(modData), .modValid(modValid),
        .pendLoads(pendLoads), .pendStores(pendStores),
        .onlyWeakLoads(onlyWeakLoads), .busOut(busOut), .busAck(busAck),
        .busRdata(busRdata), .busLock(busLock), .cacheLock(cacheLock),
        .orderHold(orderHold), .done(done), .fault(fault),
        .wasSet(wasSet), .rdData(rdData)
    );

    aabl_bus_model aabl_bus_model_i
    (
        .clk(clk), .rst(rst), .clr(clr), .busOut(busOut),
        .busLock(busLock), .dly(dly), .memVal(memVal), .busAck(busAck),
        .busRdata(busRdata), .rdBeats(rdBeats), .wrBeats(wrBeats),
        .lockBeats(lockBeats), .intBeats(intBeats), .lastWdata(lastWdata),
        .lastBe(lastBe), .lastAddr(lastAddr), .splitBeats(splitBeats)
    );

    // ========================================
    // clock, cache-lock monitor, watchdog
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
        if (cacheLock === 1'b1)
            sawCache = 1'b1;

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    // ========================================
    // shared helpers
    task automatic check(input string name, input logic [63:0] exp,
        input logic [63:0] got);
        checks_done++;
        if (exp !== got)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    function automatic aabl_req_t mk(aabl_op_t op, aabl_cls_t cls,
        logic pfx, logic [1:0] sz, logic [31:0] a, logic cach,
        logic [63:0] opd);
        aabl_req_t r;
        r = '{op: op, cls: cls, lockPrefix: pfx, memDest: 1'b1, size: sz,
            addr: a, cacheable: cach, cached: cach, operand: opd};
        return r;
    endfunction

    // one request through the handshake; waits for done or fault
    task automatic run(input aabl_req_t r);
        int n;
        n = 0;
        clr = 1'b1;
        sawCache = 1'b0;
        @(negedge clk);
        clr = 1'b0;
        req = r;
        reqValid = 1'b1;
        @(negedge clk);
        reqValid = 1'b0;
        while (done !== 1'b1 && fault !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 300)
            check("completion", 64'h1, 64'h0);
    endtask

    // ========================================
    // scenarios
    task automatic s_swap();
        memVal = 64'h00000000CAFE1234;
        pendLoads = 1'b1; // weak loads only: no wait expected
        onlyWeakLoads = 1'b1;
        run(mk(OP_INSN, CLS_SWAP, 1'b0, SZ_DWORD, 32'h100, 1'b0, '0));
        pendLoads = 1'b0;
        onlyWeakLoads = 1'b0;
        check("swap locked beats", 64'h2, 64'(lockBeats));
        check("swap wdata", MOD_VAL, lastWdata);
        check("swap rdata", memVal, rdData);
    endtask

    task automatic s_bad();
        aabl_req_t r;
        r = mk(OP_INSN, CLS_BINARY, 1'b1, SZ_DWORD, 32'h100, 1'b0, '0);
        r.memDest = 1'b0;
        run(r);
        check("reg dest fault", 64'h1, 64'(fault));
        check("reg dest beats", 64'h0, 64'(rdBeats + wrBeats));
        run(mk(OP_INSN, CLS_OTHER, 1'b1, SZ_DWORD, 32'h100, 1'b0, '0));
        check("other fault", 64'h1, 64'(fault));
        check("other beats", 64'h0, 64'(rdBeats + wrBeats));
    endtask

    task automatic s_intack();
        run(mk(OP_INT_ACK, CLS_OTHER, 1'b0, SZ_BYTE, 32'h0, 1'b0, '0));
        check("int ack beats", 64'h1, 64'(intBeats));
        check("int ack locked", 64'h1, 64'(lockBeats));
    endtask

    task automatic s_drain();
        pendStores = 1'b1;
        fork
            run(mk(OP_INSN, CLS_UNARY, 1'b1, SZ_WORD, 32'h102, 1'b0, '0));
            begin
                repeat (8) @(negedge clk);
                check("beats while draining", 64'h0, 64'(rdBeats));
                pendStores = 1'b0;
            end
        join
        check("drained locked beats", 64'h2, 64'(lockBeats));
        check("drain lanes", 64'h0C, 64'(lastBe));
        check("drain addr", 64'h100, 64'(lastAddr));
    endtask

    task automatic s_split();
        dly = 2'h3;
        run(mk(OP_INSN, CLS_SWAP_ADD, 1'b1, SZ_DWORD, 32'h106, 1'b0, '0));
        dly = 2'h0;
        check("split reads", 64'h2, 64'(rdBeats));
        check("split locked beats", 64'h4, 64'(lockBeats));
        check("split last lanes", 64'h03, 64'(lastBe));
        check("split last addr", 64'h108, 64'(lastAddr));
        check("split flagged", 64'h4, 64'(splitBeats));
    endtask

    task automatic s_cached();
        run(mk(OP_INSN, CLS_BIT_TEST, 1'b1, SZ_DWORD, 32'h145, 1'b1, '0));
        check("cache lock used", 64'h1, 64'(sawCache));
        check("pin lock beats", 64'h0, 64'(lockBeats));
        check("cached unsplit", 64'h0, 64'(splitBeats));
    endtask

    task automatic s_flags();
        memVal = 64'h100;
        run(mk(OP_DESC_ACC, CLS_OTHER, 1'b0, SZ_QWORD, 32'h200, 1'b0, memVal));
        check("desc set skip write", 64'h0, 64'(wrBeats));
        check("desc was set", 64'h1, 64'(wasSet));
        memVal = 64'h0;
        run(mk(OP_TASK_BUSY, CLS_OTHER, 1'b0, SZ_QWORD, 32'h208, 1'b0,
            64'h200));
        check("busy was set", 64'h0, 64'(wasSet));
        check("busy locked beats", 64'h2, 64'(lockBeats));
        run(mk(OP_PAGE_FLAG, CLS_OTHER, 1'b0, SZ_QWORD, 32'h300, 1'b0,
            64'h60));
        check("page flags", 64'h60, lastWdata & 64'h60);
        check("page locked beats", 64'h2, 64'(lockBeats));
    endtask

    task automatic s_plain();
        memVal = 64'hFEDCBA9876543210;
        run(mk(OP_PLAIN_RD, CLS_OTHER, 1'b0, SZ_QWORD, 32'h108, 1'b0, '0));
        check("qword beats", 64'h1, 64'(rdBeats));
        check("qword data", memVal, rdData);
        check("plain unlocked", 64'h0, 64'(lockBeats));
    endtask

    task automatic summarize();
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ========================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        req = '0;
        reqValid = 1'b0;
        modData = MOD_VAL;
        modValid = 1'b1;
        pendLoads = 1'b0;
        pendStores = 1'b0;
        onlyWeakLoads = 1'b0;
        clr = 1'b0;
        sawCache = 1'b0;
        dly = 2'h0;
        memVal = '0;
        miscompares = 0;
        checks_done = 0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        s_swap();
        s_bad();
        s_intack();
        s_drain();
        s_split();
        s_cached();
        s_flags();
        s_plain();
        summarize();
    end
endmodule
